// ==== design/sspi_defines.vh ====
// constants of the receive pointer interpreter
`ifndef SSPI_DEFINES_VH
`define SSPI_DEFINES_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define SSPI_OFS_CTRL      8'h00
`define SSPI_OFS_MASK      8'h04
`define SSPI_OFS_STATUS    8'h08
`define SSPI_OFS_PEND      8'h0C
`define SSPI_OFS_POINTER   8'h10
// ************************************************************
// field positions
// ************************************************************
`define SSPI_CTRL_SDH_BIT  0
`define SSPI_MASK_ALM_A    0
`define SSPI_MASK_LOSS_A   1
`define SSPI_MASK_ALM_B    2
`define SSPI_MASK_LOSS_B   3
`define SSPI_EVT_ALM_BIT   0
`define SSPI_EVT_LOSS_BIT  1
`define SSPI_PTR_STATE_LSB 16
// ************************************************************
// reset values
// ************************************************************
`define SSPI_CTRL_RST      1'b0
`define SSPI_MASK_RST      4'h0
`define SSPI_PTR_RST       10'h000
// ************************************************************
// pointer word layout and limits
// ************************************************************
`define SSPI_FLAG_NDF      4'h9
`define SSPI_FLAG_TRACKING_STATE     4'h6
`define SSPI_SS_SDH        2'h2
`define SSPI_ALL_ONES      16'hFFFF
`define SSPI_I_MASK        10'h2AA
`define SSPI_D_MASK        10'h155
`define SSPI_PTR_MAX       10'h30E
// ************************************************************
// persistence counts in frames and vote thresholds
// ************************************************************
`define SSPI_HOLD_FRAMES   2'h3
`define SSPI_TRACKING_STATE_FRAMES   3'h3
`define SSPI_AIS_FRAMES    3'h3
`define SSPI_LOP_FRAMES    4'h8
`define SSPI_SONET_VOTE    4'h8
`define SSPI_SDH_VOTE      4'h3
`define SSPI_SDH_OTHER     4'h2
`define SSPI_FLAG_VOTE     4'h3
`endif

// ==== design/sspi_ptr_classify.v ====
// combinational classifier of one received pointer word
`timescale 1ns/10ps
`include "sspi_defines.vh"
module sspi_ptr_classify (
  input  wire [15:0] word,     // received pointer word
  input  wire [9:0]  cur_ptr,  // currently accepted pointer
  input  wire        sdh_mode, // sdh rules when high
  output wire        is_ais,   // all-ones alarm pointer
  output wire        ndf_en,   // new data flag enabled
  output wire        ndf_tracking_state, // normal flag
  output wire        ss_ok,    // ss bits acceptable
  output wire        in_range, // value within 0..782
  output wire        inc_ind,  // increment indication
  output wire        dec_ind   // decrement indication
);
  // ************************************************************
  // population count
  // ************************************************************
  // number of ones in a ten bit vector
  function [3:0] pop10;
    input [9:0] v;
    integer k;
    begin
      pop10 = 4'h0;
      for (k = 0; k < 10; k = k + 1) begin
        pop10 = pop10 + {3'b000, v[k]};
      end
    end
  endfunction

  wire [9:0] val    = word[9:0];           // pointer value field
  wire [9:0] diff   = val ^ cur_ptr;       // bits that changed
  wire [3:0] i_inv  = pop10(diff & `SSPI_I_MASK); // inverted i bits
  wire [3:0] d_inv  = pop10(diff & `SSPI_D_MASK); // inverted d bits
  // matches against the two ideal justification patterns
  wire [3:0] inc_ok = pop10(~(val ^ (cur_ptr ^ `SSPI_I_MASK)));
  wire [3:0] dec_ok = pop10(~(val ^ (cur_ptr ^ `SSPI_D_MASK)));
  wire [3:0] ndf_m  = pop10({6'h00, ~(word[15:12] ^ `SSPI_FLAG_NDF)});
  wire [3:0] nrm_m  = pop10({6'h00, ~(word[15:12] ^ `SSPI_FLAG_TRACKING_STATE)});
  // ************************************************************
  // pointer type decisions
  // ************************************************************
  assign is_ais   = (word == `SSPI_ALL_ONES);
  // three of four flag bits decide the flag
  assign ndf_en   = (ndf_m >= `SSPI_FLAG_VOTE); // (RL19)
  assign ndf_tracking_state = (nrm_m >= `SSPI_FLAG_VOTE); // (RL19)
  // ss bits only matter under sdh rules
  assign ss_ok    = ~sdh_mode | (word[11:10] == `SSPI_SS_SDH); // (RL20)
  assign in_range = (val <= `SSPI_PTR_MAX);
  // sonet: eight of ten bits vote, sdh: majority of i or d
  assign inc_ind  = sdh_mode ?
    ((i_inv >= `SSPI_SDH_VOTE) && (d_inv <= `SSPI_SDH_OTHER)) : // (RL4)
    (inc_ok >= `SSPI_SONET_VOTE);                               // (RL2)
  assign dec_ind  = sdh_mode ?
    ((d_inv >= `SSPI_SDH_VOTE) && (i_inv <= `SSPI_SDH_OTHER)) : // (RL5)
    (dec_ok >= `SSPI_SONET_VOTE);                               // (RL3)
  // both majorities together satisfy neither term above (RL6)
endmodule // sspi_ptr_classify

// ==== design/sspi_top.v ====
// receive pointer interpreter with apb register slave
// Contract
// (RL1) no justification for three frames after one
// (RL2) sonet increment: eight of ten bits match
// (RL3) sonet decrement: eight of ten bits match
// (RL4) sdh increment: three i, two d
// (RL5) sdh decrement: three d, two i
// (RL6) sdh both majorities: no action taken
// (RL7) three states: tracking, lost, alarm
// (RL8) enabled new data flag loads pointer; the code ignores it in the pointer lost state
// (RL9) three equal normal pointers enter tracking
// (RL10) three all-ones words enter alarm state
// (RL11) eight invalid frames enter pointer lost
// (RL12) accepted justification moves pointer by one
// (RL13) alarm state accepts only all-ones pointer
// (RL14) tracking: matching normal pointer stays valid
// (RL15) alarm change sets latch-high alarm flag
// (RL16) alarm change sets pending, drives interrupts
// (RL17) loss change sets latch-high loss flag
// (RL18) loss change sets pending, drives interrupts
// (RL19) flag bits decoded by three-of-four vote
// (RL20) sdh mode checks ss bits equal 10
// (RL21) one control bit picks sonet or sdh
// (RL22) evaluate once per aligned frame
// (RL23) reset into pointer lost, all cleared
`timescale 1ns/10ps
`include "sspi_defines.vh"
module sspi_top (
  input  wire        REF_CLK,     // 50 mhz clock
  input  wire        RST,         // synchronous reset, high
  input  wire        FRAME_VALID, // one pulse per aligned frame
  input  wire [15:0] PTR_WORD,    // primary pointer word
  input  wire        PSEL,        // apb select
  input  wire        PENABLE,     // apb access phase
  input  wire        PWRITE,      // apb direction
  input  wire [7:0]  PADDR,       // apb byte address
  input  wire [31:0] PWDATA,      // apb write data
  output reg  [31:0] PRDATA,      // apb read data
  output reg         PREADY,      // apb ready
  output reg         PSLVERR,     // apb error, unmapped
  output reg         INT_A,       // interrupt output a
  output reg         INT_B        // interrupt output b
);
  // ************************************************************
  // state codes
  // ************************************************************
  localparam [1:0] TRACKING_STATE     = 2'b00; // normal tracking
  localparam [1:0] POINTER_LOST_STATE = 2'b01; // loss of pointer
  localparam [1:0] ALARM_STATE        = 2'b10; // alarm indication

  // ************************************************************
  // storage
  // ************************************************************
  reg  [1:0] state_reg;      // interpreter state
  reg  [1:0] state_next;
  reg  [9:0] ptr_reg;        // accepted pointer
  reg  [9:0] ptr_next;
  reg  [9:0] cand_reg;       // last normal pointer value seen
  reg  [9:0] cand_next;
  reg  [2:0] same_cnt_reg;   // equal normal pointers in a row
  reg  [2:0] same_cnt_next;
  reg  [2:0] ais_cnt_reg;    // all-ones words in a row
  reg  [2:0] ais_cnt_next;
  reg  [3:0] inv_cnt_reg;    // invalid frames in a row
  reg  [3:0] inv_cnt_next;
  reg  [1:0] hold_reg;       // frames left barring justification
  reg  [1:0] hold_next;
  reg        sdh_mode_reg;   // receive mode select
  reg  [3:0] mask_reg;       // interrupt masks
  reg        path_alarm_flag_reg;      // latch-high alarm
  reg        path_alarm_flag_next;
  reg        pointer_loss_flag_reg;    // latch-high loss
  reg        pointer_loss_flag_next;
  reg        path_alarm_pending_reg;   // clear-on-read alarm
  reg        path_alarm_pending_next;
  reg        pointer_loss_pending_reg; // clear-on-read loss
  reg        pointer_loss_pending_next;
  reg  [31:0] rdata_next;    // read data for next access
  reg        err_next;       // unmapped address

  // classifier results
  wire       is_ais;
  wire       new_data_flag;
  wire       flag_tracking_state;
  wire       ss_ok;
  wire       in_range;
  wire       inc_ind;
  wire       dec_ind;

  // ************************************************************
  // pointer word classifier
  // ************************************************************
  sspi_ptr_classify u_classify (
    .word     (PTR_WORD),
    .cur_ptr  (ptr_reg),
    .sdh_mode (sdh_mode_reg),
    .is_ais   (is_ais),
    .ndf_en   (new_data_flag),
    .ndf_tracking_state (flag_tracking_state),
    .ss_ok    (ss_ok),
    .in_range (in_range),
    .inc_ind  (inc_ind),
    .dec_ind  (dec_ind)
  );

  // ************************************************************
  // frame qualifiers
  // ************************************************************
  // enabled new data flag with a usable value
  wire ndf_ok  = new_data_flag & in_range & ss_ok;
  // normal flag with a usable value
  wire tracking_state_ok = flag_tracking_state & in_range & ss_ok;
  // justification candidate, valid only when not barred
  wire just    = flag_tracking_state & ss_ok & (inc_ind | dec_ind) &
                 (PTR_WORD[9:0] != ptr_reg);
  wire just_ok = just & (hold_reg == 2'h0);             // (RL1)
  wire in_trk  = (state_reg == TRACKING_STATE);
  wire in_alm  = (state_reg == ALARM_STATE);

  // ************************************************************
  // apb handshake terms
  // ************************************************************
  wire setup  = PSEL & ~PENABLE;             // setup cycle
  wire acc    = PSEL & PENABLE & PREADY;     // completing edge
  wire wr     = acc & PWRITE;                // write takes effect
  wire rd     = acc & ~PWRITE;               // read completes
  wire rd_st  = rd & (PADDR == `SSPI_OFS_STATUS);
  wire rd_pd  = rd & (PADDR == `SSPI_OFS_PEND);

  // ************************************************************
  // per-frame interpreter
  // ************************************************************
  // all counters hold between frames (RL22)
  always @* begin
    state_next    = state_reg;
    ptr_next      = ptr_reg;
    cand_next     = cand_reg;
    same_cnt_next = same_cnt_reg;
    ais_cnt_next  = ais_cnt_reg;
    inv_cnt_next  = inv_cnt_reg;
    hold_next     = hold_reg;
    if (FRAME_VALID) begin                                 // (RL22)
      // bar counts down one per frame
      if (hold_reg != 2'h0) begin
        hold_next = hold_reg - 2'h1;
      end
      // run of all-ones words
      if (is_ais) begin
        ais_cnt_next = (ais_cnt_reg == `SSPI_AIS_FRAMES) ?
                       ais_cnt_reg : ais_cnt_reg + 3'h1;
      end else begin
        ais_cnt_next = 3'h0;
      end
      // run of equal normal pointers
      if (tracking_state_ok && !is_ais) begin
        if (PTR_WORD[9:0] == cand_reg && same_cnt_reg != 3'h0) begin
          same_cnt_next = (same_cnt_reg == `SSPI_TRACKING_STATE_FRAMES) ?
                          same_cnt_reg : same_cnt_reg + 3'h1;
        end else begin
          same_cnt_next = 3'h1;
        end
        cand_next = PTR_WORD[9:0];
      end else begin
        same_cnt_next = 3'h0;
      end
      // validity for loss detection
      if (in_alm) begin
        // only the all-ones word is valid here
        inv_cnt_next = is_ais ? 4'h0 : inv_cnt_reg + 4'h1; // (RL13)
      end else if (in_trk) begin
        if (ndf_ok || just_ok ||
            (tracking_state_ok && PTR_WORD[9:0] == ptr_reg)) begin // (RL14)
          inv_cnt_next = 4'h0;
        end else begin
          inv_cnt_next = inv_cnt_reg + 4'h1;
        end
      end else begin
        inv_cnt_next = 4'h0;
      end
      // transitions, alarm first, then persistence, then flags
      if (ais_cnt_next == `SSPI_AIS_FRAMES && !in_alm) begin
        state_next   = ALARM_STATE;                       // (RL10)
        inv_cnt_next = 4'h0;
      end else if (same_cnt_next == `SSPI_TRACKING_STATE_FRAMES &&
                   !(in_trk && PTR_WORD[9:0] == ptr_reg)) begin
        state_next   = TRACKING_STATE;                    // (RL9)
        ptr_next     = PTR_WORD[9:0];
        inv_cnt_next = 4'h0;
      end else if (ndf_ok && !is_ais && !(state_reg ==
                   POINTER_LOST_STATE)) begin
        state_next   = TRACKING_STATE;                    // (RL8)
        ptr_next     = PTR_WORD[9:0];
        hold_next    = `SSPI_HOLD_FRAMES;                 // (RL1)
        inv_cnt_next = 4'h0;
      end else if (in_trk && just_ok) begin
        // one step, wrapping inside 0..782
        if (inc_ind) begin                                // (RL12)
          ptr_next = (ptr_reg == `SSPI_PTR_MAX) ? 10'h000 :
                     ptr_reg + 10'h001;
        end else begin
          ptr_next = (ptr_reg == 10'h000) ? `SSPI_PTR_MAX :
                     ptr_reg - 10'h001;
        end
        hold_next = `SSPI_HOLD_FRAMES;                    // (RL1)
      end else if (inv_cnt_next == `SSPI_LOP_FRAMES) begin
        state_next   = POINTER_LOST_STATE;                // (RL11)
        inv_cnt_next = 4'h0;
      end
    end
  end

  // ************************************************************
  // state changes as events
  // ************************************************************
  wire alm_chg  = (state_next != state_reg) &&
                  (state_next == ALARM_STATE || in_alm);
  wire loss_chg = (state_next != state_reg) &&
                  (state_next == POINTER_LOST_STATE ||
                   state_reg == POINTER_LOST_STATE);
  wire alm_now  = (state_next == ALARM_STATE);
  wire loss_now = (state_next == POINTER_LOST_STATE);

  // ************************************************************
  // alarm and pending bits
  // ************************************************************
  // an event wins over the read that would clear it
  always @* begin
    path_alarm_flag_next      = path_alarm_flag_reg;
    pointer_loss_flag_next    = pointer_loss_flag_reg;
    path_alarm_pending_next   = path_alarm_pending_reg;
    pointer_loss_pending_next = pointer_loss_pending_reg;
    // latch-high: read hands back event, then status
    if (alm_chg) begin
      path_alarm_flag_next = 1'b1;                        // (RL15)
    end else if (rd_st) begin
      path_alarm_flag_next = alm_now;                     // (RL15)
    end
    if (loss_chg) begin
      pointer_loss_flag_next = 1'b1;                      // (RL17)
    end else if (rd_st) begin
      pointer_loss_flag_next = loss_now;                  // (RL17)
    end
    // pending: only a bit returned as one is cleared
    if (alm_chg) begin
      path_alarm_pending_next = 1'b1;                     // (RL16)
    end else if (rd_pd && PRDATA[`SSPI_EVT_ALM_BIT]) begin
      path_alarm_pending_next = 1'b0;
    end
    if (loss_chg) begin
      pointer_loss_pending_next = 1'b1;                   // (RL18)
    end else if (rd_pd && PRDATA[`SSPI_EVT_LOSS_BIT]) begin
      pointer_loss_pending_next = 1'b0;
    end
  end

  // ************************************************************
  // read data mux, sampled in the setup cycle
  // ************************************************************
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    case (PADDR)
      `SSPI_OFS_CTRL: begin
        rdata_next[`SSPI_CTRL_SDH_BIT] = sdh_mode_reg;
      end
      `SSPI_OFS_MASK: begin
        rdata_next[3:0] = mask_reg;
      end
      `SSPI_OFS_STATUS: begin
        rdata_next[`SSPI_EVT_ALM_BIT]  = path_alarm_flag_next;
        rdata_next[`SSPI_EVT_LOSS_BIT] = pointer_loss_flag_next;
      end
      `SSPI_OFS_PEND: begin
        rdata_next[`SSPI_EVT_ALM_BIT]  = path_alarm_pending_next;
        rdata_next[`SSPI_EVT_LOSS_BIT] = pointer_loss_pending_next;
      end
      `SSPI_OFS_POINTER: begin
        rdata_next[9:0] = ptr_reg;
        rdata_next[`SSPI_PTR_STATE_LSB+1:`SSPI_PTR_STATE_LSB] =
          state_reg;
      end
      default: begin
        // unmapped address answers with an error
        err_next = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // interpreter registers
  // ************************************************************
  always @(posedge REF_CLK) begin
    if (RST) begin
      state_reg    <= POINTER_LOST_STATE;                 // (RL23)
      ptr_reg      <= `SSPI_PTR_RST;
      cand_reg     <= `SSPI_PTR_RST;
      same_cnt_reg <= 3'h0;
      ais_cnt_reg  <= 3'h0;
      inv_cnt_reg  <= 4'h0;
      hold_reg     <= 2'h0;
      path_alarm_flag_reg      <= 1'b0;
      pointer_loss_flag_reg    <= 1'b0;
      path_alarm_pending_reg   <= 1'b0;
      pointer_loss_pending_reg <= 1'b0;
    end else begin
      // three-state machine advances (RL7)
      state_reg    <= state_next;                         // (RL7)
      ptr_reg      <= ptr_next;
      cand_reg     <= cand_next;
      same_cnt_reg <= same_cnt_next;
      ais_cnt_reg  <= ais_cnt_next;
      inv_cnt_reg  <= inv_cnt_next;
      hold_reg     <= hold_next;
      path_alarm_flag_reg      <= path_alarm_flag_next;
      pointer_loss_flag_reg    <= pointer_loss_flag_next;
      path_alarm_pending_reg   <= path_alarm_pending_next;
      pointer_loss_pending_reg <= pointer_loss_pending_next;
    end
  end

  // ************************************************************
  // apb slave and interrupt outputs
  // ************************************************************
  // ready rises in the access cycle: one access cycle per transfer
  always @(posedge REF_CLK) begin
    if (RST) begin
      sdh_mode_reg <= `SSPI_CTRL_RST;
      mask_reg     <= `SSPI_MASK_RST;
      PRDATA       <= 32'h0000_0000;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      INT_A        <= 1'b0;
      INT_B        <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & err_next;
      if (setup && !PWRITE) begin
        PRDATA <= rdata_next;
      end else if (acc) begin
        PRDATA <= 32'h0000_0000;
      end
      if (wr && PADDR == `SSPI_OFS_CTRL) begin
        sdh_mode_reg <= PWDATA[`SSPI_CTRL_SDH_BIT];       // (RL21)
      end
      if (wr && PADDR == `SSPI_OFS_MASK) begin
        mask_reg <= PWDATA[3:0];
      end
      // each pending bit gated by its own mask per output
      INT_A <= (path_alarm_pending_next &
                mask_reg[`SSPI_MASK_ALM_A]) |             // (RL16)
               (pointer_loss_pending_next &
                mask_reg[`SSPI_MASK_LOSS_A]);             // (RL18)
      INT_B <= (path_alarm_pending_next &
                mask_reg[`SSPI_MASK_ALM_B]) |             // (RL16)
               (pointer_loss_pending_next &
                mask_reg[`SSPI_MASK_LOSS_B]);             // (RL18)
    end
  end
endmodule // sspi_top

// ==== tb/sspi_chk.sv ====
// assertions on the register and interrupt ports
`timescale 1ns/10ps
module sspi_chk (
  input wire        REF_CLK,     // frame clock
  input wire        RST,         // synchronous reset
  input wire        FRAME_VALID, // frame pulse
  input wire        PSEL,        // apb select
  input wire        PENABLE,     // apb access phase
  input wire [31:0] PRDATA,      // apb read data
  input wire        PREADY,      // apb ready
  input wire        PSLVERR,     // apb error
  input wire        INT_A,       // interrupt a
  input wire        INT_B        // interrupt b
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without setup");
  a_data_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_reset_quiet: assert property (disable iff (1'b0)
    RST |=> !INT_A && !INT_B && !PREADY)
    else $error("outputs active after reset");
  // a frame raises pending and the interrupt at its own edge, a mask
  // write reaches the interrupt one edge after the write completes
  a_int_a_rise: assert property ($rose(INT_A) |->
    $past(FRAME_VALID) || $past(PSEL && PENABLE, 2))
    else $error("interrupt a rose without cause");
  a_int_b_rise: assert property ($rose(INT_B) |->
    $past(FRAME_VALID) || $past(PSEL && PENABLE, 2))
    else $error("interrupt b rose without cause");
  // a pending read clears at its completing edge, a mask write later
  a_int_fall: assert property ($fell(INT_A) || $fell(INT_B) |->
    $past(PSEL && PENABLE) || $past(PSEL && PENABLE, 2) || $past(RST))
    else $error("interrupt fell without access");
endmodule // sspi_chk

// ==== tb/sspi_far_end.sv ====
// far-end transmitter model sending one pointer word per frame
`timescale 1ns/10ps
module sspi_far_end (
  input  wire        clk,         // frame clock
  output reg         frame_valid, // one pulse per frame
  output reg  [15:0] ptr_word     // pointer word of the frame
);
  integer gap = 3; // idle cycles between frames less one, raise for slow frames
  initial begin
    frame_valid = 1'b0;
    ptr_word = 16'h0000;
  end
  // one frame, then junk on the word lines until the next one
  task send(input [15:0] w);
    begin
      @(posedge clk);
      frame_valid <= 1'b1;
      ptr_word <= w;
      @(posedge clk);
      frame_valid <= 1'b0;
      ptr_word <= ~w;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // sspi_far_end

// ==== tb/tb_top.sv ====
// self-checking bench of the receive pointer interpreter
`timescale 1ns/10ps
`include "sspi_defines.vh"
module tb_top;
  reg         clk = 1'b0;     // 50 mhz
  reg         rst = 1'b1;     // synchronous reset
  reg         psel = 1'b0;    // apb select
  reg         pen = 1'b0;     // apb access phase
  reg         pwr = 1'b0;     // apb direction
  reg  [7:0]  paddr = 8'h00;  // apb address
  reg  [31:0] pwdata = 32'h0; // apb write data
  wire [31:0] prdata;         // apb read data
  wire        pready;         // apb ready
  wire        pslverr;        // apb error
  wire        int_a;          // interrupt a
  wire        int_b;          // interrupt b
  wire        fv;             // frame pulse
  wire [15:0] pw;             // pointer word
  reg  [32:0] expq[$];        // expected error bit and read data
  integer     bad_count = 0;  // mismatches
  integer     compares = 0;   // comparisons
  integer     seed = 53501;   // random seed
  integer     k;              // loop index
  reg  [9:0]  c;              // expected accepted pointer
  sspi_top i_dut (.REF_CLK(clk), .RST(rst), .FRAME_VALID(fv), .PTR_WORD(pw),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INT_A(int_a),
    .INT_B(int_b));
  sspi_far_end i_far (.clk(clk), .frame_valid(fv), .ptr_word(pw));
  // ****
  // clock, tasks and read monitor
  // ****
  initial forever #10 clk = ~clk;
  task check(input [32:0] seen, input [32:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // one apb transfer, waits for ready under a bound
  task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
    integer t;
    begin
      if (!w) expq.push_back(e);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      t = 0;
      do begin
        @(posedge clk);
        t = t + 1;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) begin
        bad_count = bad_count + 1;
        final_report;
      end
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [32:0] e); apb(1'b0, a, 32'h0, e); endtask
  task wr(input [7:0] a, input [31:0] d); apb(1'b1, a, d, 33'h0); endtask
  function [15:0] nw(input [9:0] p);
    nw = {`SSPI_FLAG_TRACKING_STATE, `SSPI_SS_SDH, p};
  endfunction
  // send a frame, then read the pointer register
  task fr(input [15:0] w, input [1:0] s, input [9:0] p);
    begin
      i_far.send(w);
      rd(`SSPI_OFS_POINTER, {15'h0, s, 6'h0, p});
    end
  endtask
  task chk_int(input a, input b);
    begin
      @(negedge clk);
      check({32'h0, int_a}, {32'h0, a});
      check({32'h0, int_b}, {32'h0, b});
      @(posedge clk);
    end
  endtask
  // compares every completed read with the oldest note
  always @(posedge clk)
    if (pready === 1'b1 && pwr === 1'b0)
      check({pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : '1);
  // ****
  // main sequence
  // ****
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    c = 10'({$random(seed)} % 782);
    rd(`SSPI_OFS_CTRL, 33'h0);
    rd(`SSPI_OFS_MASK, 33'h0);
    rd(`SSPI_OFS_STATUS, 33'h0);
    rd(`SSPI_OFS_PEND, 33'h0);
    rd(`SSPI_OFS_POINTER, 33'h10000);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 33'h100000000);
    wr(`SSPI_OFS_MASK, 32'hF);
    for (k = 0; k < 3; k = k + 1) i_far.send({4'h6 ^ (4'h1 << k), 2'h2, c});
    rd(`SSPI_OFS_POINTER, {23'h0, c});
    chk_int(1'b1, 1'b1);
    rd(`SSPI_OFS_STATUS, 33'h2);
    rd(`SSPI_OFS_STATUS, 33'h0);
    rd(`SSPI_OFS_PEND, 33'h2);
    rd(`SSPI_OFS_PEND, 33'h0);
    chk_int(1'b0, 1'b0);
    $display("test reset and tracking done");
    fr(nw(c ^ `SSPI_I_MASK ^ 10'h005), 2'h0, c + 10'h1);
    fr(nw((c + 10'h1) ^ `SSPI_D_MASK), 2'h0, c + 10'h1);
    repeat (2) i_far.send(nw(c + 10'h1));
    fr(nw((c + 10'h1) ^ `SSPI_D_MASK ^ 10'h02A), 2'h0, c + 10'h1);
    fr(nw((c + 10'h1) ^ `SSPI_D_MASK), 2'h0, c);
    $display("test sonet justification done");
    wr(`SSPI_OFS_CTRL, 32'h1);
    rd(`SSPI_OFS_CTRL, 33'h1);
    i_far.gap = 9;
    repeat (3) i_far.send(nw(c));
    fr(nw(c ^ 10'h02A), 2'h0, c + 10'h1);
    repeat (3) i_far.send(nw(c + 10'h1));
    fr(nw((c + 10'h1) ^ 10'h01F), 2'h0, c);
    repeat (3) i_far.send(nw(c));
    fr(nw(c ^ 10'h03F), 2'h0, c);
    fr({`SSPI_FLAG_NDF, 2'h1, c ^ 10'h001}, 2'h0, c);
    c = c ^ 10'h001;
    fr({`SSPI_FLAG_NDF, 2'h2, c}, 2'h0, c);
    $display("test sdh rules done");
    for (k = 0; k < 15; k = k + 1)
      if (k == 7) fr(nw(c), 2'h0, c);
      else i_far.send(nw(c ^ 10'(k % 2 + 1)));
    fr(nw(c ^ 10'h001), 2'h1, c);
    rd(`SSPI_OFS_STATUS, 33'h2);
    rd(`SSPI_OFS_STATUS, 33'h2);
    $display("test pointer loss done");
    repeat (3) i_far.send(`SSPI_ALL_ONES);
    rd(`SSPI_OFS_POINTER, {15'h0, 2'h2, 6'h0, c});
    rd(`SSPI_OFS_STATUS, 33'h3);
    rd(`SSPI_OFS_STATUS, 33'h1);
    for (k = 0; k < 6; k = k + 1) i_far.send(nw(c ^ 10'(k % 2 + 1)));
    fr(nw(c ^ 10'h001), 2'h2, c);
    fr(nw(c), 2'h1, c);
    rd(`SSPI_OFS_STATUS, 33'h3);
    rd(`SSPI_OFS_STATUS, 33'h2);
    wr(`SSPI_OFS_MASK, 32'h1);
    chk_int(1'b1, 1'b0);
    wr(`SSPI_OFS_MASK, 32'h8);
    chk_int(1'b0, 1'b1);
    rd(`SSPI_OFS_PEND, 33'h3);
    rd(`SSPI_OFS_PEND, 33'h0);
    chk_int(1'b0, 1'b0);
    $display("test alarm and interrupts done");
    final_report;
  end
endmodule // tb_top
bind sspi_top sspi_chk i_chk (.REF_CLK(REF_CLK), .RST(RST),
  .FRAME_VALID(FRAME_VALID), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INT_A(INT_A),
  .INT_B(INT_B));
